// file: include/sfes_pkg.sv
// shared constants and types of the serial flash erase/suspend sequencer
// assumes a 25 MHz system clock; command link pins arrive asynchronously
package sfes_pkg;

  // timing base
  localparam int CLK_PERIOD_NS = 40;
  localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
  // resume must show busy within this time (longest: rounds down)
  localparam int RESUME_BUSY_NS = 200;
  localparam int RESUME_BUSY_CYC = RESUME_BUSY_NS / CLK_PERIOD_NS;
  // suspend latency, plain default
  localparam int SUSPEND_LAT_US = 20;
  localparam int SUSPEND_LAT_CYC = SUSPEND_LAT_US * CYC_PER_US;
  // self-timed durations, plain defaults in microseconds
  localparam int SECTOR_ERASE_TIME_US = 50000;
  localparam int SMALL_BLOCK_ERASE_TIME_US = 120000;
  localparam int BLOCK_ERASE_TIME_US = 150000;
  localparam int CHIP_ERASE_TIME_US = 50000000;
  localparam int PAGE_PROGRAM_TIME_US = 700;
  localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_US * CYC_PER_US;
  localparam int SMALL_BLOCK_ERASE_CYC = SMALL_BLOCK_ERASE_TIME_US * CYC_PER_US;
  localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_US * CYC_PER_US;
  localparam int CHIP_ERASE_CYC = CHIP_ERASE_TIME_US * CYC_PER_US;
  localparam int PAGE_PROGRAM_CYC = PAGE_PROGRAM_TIME_US * CYC_PER_US;

  // command opcodes
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] CMD_SECTOR_ERASE_A32 = 8'h21;
  localparam logic [7:0] CMD_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] CMD_BLOCK64_ERASE = 8'hd8;
  localparam logic [7:0] CMD_BLOCK64_ERASE_A32 = 8'hdc;
  localparam logic [7:0] CMD_CHIP_ERASE_A = 8'hc7;
  localparam logic [7:0] CMD_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
  localparam logic [7:0] CMD_PAGE_PROG_A32 = 8'h12;
  localparam logic [7:0] CMD_QUAD_PROG = 8'h32;
  localparam logic [7:0] CMD_QUAD_PROG_A32 = 8'h34;
  localparam logic [7:0] CMD_SUSPEND = 8'h75;
  localparam logic [7:0] CMD_RESUME = 8'h7a;

  // bit counts on the link, and the number of 64K blocks
  localparam logic [11:0] OPCODE_BITS = 12'h008;
  localparam logic [11:0] HDR3_BITS = 12'h020;
  localparam logic [11:0] HDR4_BITS = 12'h028;
  localparam logic [11:0] DATA_BYTE_BITS = 12'h008;
  localparam logic [11:0] CNT_SAT = 12'hff8;
  localparam int BLOCK64_TOTAL = 512;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PROTECT = 8'h04;
  localparam logic [7:0] REG_LOCK = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_LAST_BASE = 8'h10;
  // field positions
  localparam int CTRL_ADDR4_BIT = 0;
  localparam int CTRL_QUAD_BIT = 1;
  localparam int PROT_TOP_BOTTOM_BIT = 4;
  localparam int PROT_COMPLEMENT_BIT = 5;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WLATCH_BIT = 1;
  localparam int STAT_SUSPEND_BIT = 2;
  localparam int STAT_REFUSED_BIT = 3;
  // reset values
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [5:0] PROTECT_RST = 6'h00;
  localparam logic [31:0] LOCK_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_SUSPENDING = 2'b11,
    ST_SUSPENDED = 2'b10
  } sfes_state_type;

  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_SECTOR = 3'h1,
    K_BLOCK32 = 3'h2,
    K_BLOCK64 = 3'h3,
    K_CHIP = 3'h4,
    K_PROGRAM = 3'h5
  } sfes_kind_type;

  // command link pins, host to device
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic [3:0] io;
  } sfes_link_type;

  // completion report to the array
  typedef struct packed {
    logic valid;
    sfes_kind_type kind;
    logic [31:0] base;
  } sfes_report_type;

endpackage : sfes_pkg

// file: tb/sfes_host.sv
// host model: sends command frames on the flash link, single-line or quad mode
// assumes the device samples the link with its own 25 MHz clock
`timescale 1ns/1ps
module sfes_host import sfes_pkg::*; (
  // clock
  input wire logic clk,
  // link pins to the device
  output sfes_link_type link
);
  // idle link: select high, clock stands still
  initial begin
    link = '{cs_n: 1'b1, sck: 1'b0, io: 4'hf};
  end
  // opcode then abits of address, msb first, 320 ns per sck
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input int abits);
    logic [39:0] v;
    v = {op, a << (32 - abits)};
    link.cs_n <= 1'b0;
    for (int i = 0; i < 8 + abits; i++) begin
      link.io[0] <= v[39 - i];
      repeat (4) @(posedge clk);
      link.sck <= 1'b1;
      repeat (4) @(posedge clk);
      link.sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    link.cs_n <= 1'b1;
    link.io[0] <= ~v[40 - 8 - abits]; // released line shows inverse
    repeat (16) @(posedge clk);
  endtask : frame
  // same frame, four bits per sck for quad command mode
  task automatic frame4(input logic [7:0] op, input logic [31:0] a, input int abits);
    logic [39:0] v;
    v = {op, a << (32 - abits)};
    link.cs_n <= 1'b0;
    for (int i = 0; i < (8 + abits) / 4; i++) begin
      link.io <= v[39 - 4 * i -: 4];
      repeat (4) @(posedge clk);
      link.sck <= 1'b1;
      repeat (4) @(posedge clk);
      link.sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    link.cs_n <= 1'b1;
    link.io <= ~v[43 - 8 - abits -: 4];
    repeat (16) @(posedge clk);
  endtask : frame4
endmodule : sfes_host

// file: tb/tb_serial_flash_erase_suspend.sv
// bench of the erase/suspend sequencer: ahb-lite master, link host model
// assumes hreadyout is fed back as hready
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", n, e, a); end end
module tb_serial_flash_erase_suspend import sfes_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic hsel = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, busy_flag, write_latch_flag, suspend_flag;
  logic [31:0] hrdata;
  sfes_link_type link;
  sfes_report_type erase_report, rep;
  int rep_n = 0;
  int cyc = 0;
  int fail_count = 0;
  int check_count = 0;
  sfes_core #(.SECTOR_CYC(60), .BLOCK32_CYC(80), .BLOCK64_CYC(400), .CHIP_CYC(300),
    .PROGRAM_CYC(200)) uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_in(link),
    .busy_flag(busy_flag), .write_latch_flag(write_latch_flag),
    .suspend_flag(suspend_flag), .erase_report(erase_report));
  sfes_host u_host (.clk(clk), .link(link));
  // clock
  initial begin
    forever #20 clk = ~clk;
  end
  // completion capture and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (erase_report.valid === 1'b1) begin
      rep <= erase_report;
      rep_n <= rep_n + 1;
    end
    if (cyc == 30000) begin
      fail_count++;
      complete_run;
    end
  end
  // one single ahb transfer, master waits on hready in both phases
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    htrans <= 2'h2;
    hsel <= 1'b1;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // wait for busy low, bounded, and let the report land
  task automatic wait_idle(output int n);
    n = 0;
    while (busy_flag !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    `CHK("idle", 1'b0, busy_flag)
    repeat (3) @(posedge clk);
  endtask : wait_idle
  // refused flag set, then cleared by writing one
  task automatic chk_refused;
    logic [31:0] d;
    ahb(1'b0, REG_STATUS, 32'h0, d);
    `CHK("refused", 1'b1, d[STAT_REFUSED_BIT])
    `CHK("okay", 1'b0, hresp)
    ahb(1'b1, REG_STATUS, 32'h1 << STAT_REFUSED_BIT, d);
    ahb(1'b0, REG_STATUS, 32'h0, d);
    `CHK("cleared", 1'b0, d[STAT_REFUSED_BIT])
  endtask : chk_refused
  // full erase with latch, busy and report checks
  task automatic do_erase(input logic [7:0] op, input logic [31:0] a, input int ab,
    input sfes_kind_type k, input logic [31:0] base);
    int n0, n;
    logic [31:0] d;
    n0 = rep_n;
    u_host.frame(CMD_WRITE_ENABLE, 32'h0, 0);
    `CHK("latch set", 1'b1, write_latch_flag)
    u_host.frame(op, a, ab);
    `CHK("busy", 1'b1, busy_flag)
    ahb(1'b0, REG_STATUS, 32'h0, d);
    `CHK("stat busy", 2'b11, {d[STAT_WLATCH_BIT], d[STAT_BUSY_BIT]})
    wait_idle(n);
    `CHK("latch clr", 1'b0, write_latch_flag)
    `CHK("reports", n0 + 1, rep_n)
    ahb(1'b0, REG_LAST_BASE, 32'h0, d);
    `CHK("last base", base, d)
    `CHK("kind", k, rep.kind)
    `CHK("base", base, rep.base)
  endtask : do_erase
  task automatic t_erase;
    logic [31:0] d;
    int n;
    do_erase(CMD_SECTOR_ERASE, 32'h12345, 24, K_SECTOR, 32'h12000);
    do_erase(CMD_BLOCK32_ERASE, 32'h123456, 24, K_BLOCK32, 32'h120000);
    do_erase(CMD_BLOCK64_ERASE, 32'h123456, 24, K_BLOCK64, 32'h120000);
    do_erase(CMD_CHIP_ERASE_A, 32'h0, 0, K_CHIP, 32'h0);
    do_erase(CMD_CHIP_ERASE_B, 32'h0, 0, K_CHIP, 32'h0);
    do_erase(CMD_SECTOR_ERASE_A32, 32'h1abcdef, 32, K_SECTOR, 32'h1abc000);
    do_erase(CMD_BLOCK64_ERASE_A32, 32'h1abcdef, 32, K_BLOCK64, 32'h1ab0000);
    ahb(1'b1, REG_CTRL, 32'h1, d);
    do_erase(CMD_SECTOR_ERASE, 32'h1abcdef, 32, K_SECTOR, 32'h1abc000);
    ahb(1'b1, REG_CTRL, 32'h2, d);
    u_host.frame4(CMD_WRITE_ENABLE, 32'h0, 0);
    u_host.frame4(CMD_BLOCK32_ERASE, 32'h2b456, 24);
    wait_idle(n);
    `CHK("quad kind", K_BLOCK32, rep.kind)
    `CHK("quad base", 32'h28000, rep.base)
    ahb(1'b1, REG_CTRL, 32'h0, d);
    $display("test erase done");
  endtask : t_erase
  task automatic t_refuse;
    logic [31:0] d;
    u_host.frame(CMD_SECTOR_ERASE, 32'h1000, 24);
    `CHK("no latch", 1'b0, busy_flag)
    chk_refused;
    u_host.frame(CMD_WRITE_ENABLE, 32'h0, 0);
    u_host.frame(CMD_SECTOR_ERASE, 32'h1000, 16);
    `CHK("short", 1'b0, busy_flag)
    chk_refused;
    u_host.frame(CMD_SECTOR_ERASE_A32, 32'h1000, 24);
    `CHK("short a32", 1'b0, busy_flag)
    chk_refused;
    ahb(1'b1, REG_PROTECT, 32'ha, d);
    u_host.frame(CMD_WRITE_ENABLE, 32'h0, 0);
    u_host.frame(CMD_SECTOR_ERASE, 32'h1000, 24);
    `CHK("protected", 1'b0, busy_flag)
    chk_refused;
    ahb(1'b1, REG_PROTECT, 32'h0, d);
    ahb(1'b1, REG_LOCK, 32'h1, d);
    u_host.frame(CMD_WRITE_ENABLE, 32'h0, 0);
    u_host.frame(CMD_CHIP_ERASE_A, 32'h0, 0);
    `CHK("locked", 1'b0, busy_flag)
    chk_refused;
    ahb(1'b1, REG_LOCK, 32'h0, d);
    $display("test refuse done");
  endtask : t_refuse
  // program suspend, refused program, nested erase, resume
  task automatic t_program;
    int n;
    u_host.frame(CMD_WRITE_ENABLE, 32'h0, 0);
    u_host.frame(CMD_PAGE_PROG, 32'h345678a5, 32); // address then one data byte
    u_host.frame(CMD_SUSPEND, 32'h0, 0);
    `CHK("prog susp", 1'b1, suspend_flag)
    wait_idle(n);
    u_host.frame(CMD_PAGE_PROG, 32'h100000a5, 32);
    `CHK("no prog", 1'b0, busy_flag)
    chk_refused;
    u_host.frame(CMD_SECTOR_ERASE, 32'h200000, 24);
    `CHK("nested", 1'b1, busy_flag)
    wait_idle(n);
    `CHK("nest kind", K_SECTOR, rep.kind)
    u_host.frame(CMD_RESUME, 32'h0, 0);
    wait_idle(n);
    `CHK("prog kind", K_PROGRAM, rep.kind)
    `CHK("prog base", 32'h345678, rep.base)
    $display("test program done");
  endtask : t_program
  task automatic t_suspend;
    int n;
    u_host.frame(CMD_SUSPEND, 32'h0, 0);
    `CHK("idle susp", 1'b0, suspend_flag)
    u_host.frame(CMD_WRITE_ENABLE, 32'h0, 0);
    u_host.frame(CMD_BLOCK64_ERASE, 32'h10000, 24);
    u_host.frame(CMD_SUSPEND, 32'h0, 0);
    `CHK("susp", 1'b1, suspend_flag)
    wait_idle(n);
    `CHK("latency", 1'b1, n <= SUSPEND_LAT_CYC)
    u_host.frame(CMD_WRITE_ENABLE, 32'h0, 0);
    u_host.frame(CMD_CHIP_ERASE_A, 32'h0, 0);
    `CHK("no erase", 1'b0, busy_flag)
    chk_refused;
    u_host.frame(CMD_RESUME, 32'h0, 0);
    `CHK("resumed", 2'b01, {suspend_flag, busy_flag})
    wait_idle(n);
    `CHK("kind", K_BLOCK64, rep.kind)
    u_host.frame(CMD_WRITE_ENABLE, 32'h0, 0);
    u_host.frame(CMD_CHIP_ERASE_B, 32'h0, 0);
    u_host.frame(CMD_SUSPEND, 32'h0, 0);
    `CHK("chip susp", 1'b0, suspend_flag)
    wait_idle(n);
    u_host.frame(CMD_WRITE_ENABLE, 32'h0, 0);
    u_host.frame(CMD_BLOCK64_ERASE, 32'h10000, 24);
    u_host.frame(CMD_SUSPEND, 32'h0, 0);
    `CHK("susp again", 1'b1, suspend_flag)
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("reset susp", 2'b00, {suspend_flag, busy_flag})
    repeat (4) @(posedge clk);
    $display("test suspend done");
  endtask : t_suspend
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_erase;
    t_refuse;
    t_program;
    t_suspend;
    complete_run;
  end
endmodule : tb_serial_flash_erase_suspend

// file: verilog/sfes_core.sv
// erase, program and suspend sequencer of a serial flash, AHB-Lite register slave
// assumes link pins are asynchronous and sampled here; the array sits outside
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
module sfes_core import sfes_pkg::*; #(
  parameter int unsigned SECTOR_CYC = SECTOR_ERASE_CYC,
  parameter int unsigned BLOCK32_CYC = SMALL_BLOCK_ERASE_CYC,
  parameter int unsigned BLOCK64_CYC = BLOCK_ERASE_CYC,
  parameter int unsigned CHIP_CYC = CHIP_ERASE_CYC,
  parameter int unsigned PROGRAM_CYC = PAGE_PROGRAM_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // command link
  input wire sfes_link_type link_in,
  // status and array report
  output logic busy_flag,
  output logic write_latch_flag,
  output logic suspend_flag,
  output sfes_report_type erase_report
);
  localparam int SUS_BOUND = SUSPEND_LAT_CYC + 1;
  localparam int RES_BOUND = RESUME_BUSY_CYC;

  sfes_link_type link_q;
  logic sck_d_r, cs_d_r, sck_rise, cs_rise, step4, quad_data;
  logic [11:0] cnt_r, hdr_bits;
  logic [7:0] op_r;
  logic [31:0] adr_r, tgt, base_new;
  logic [1:0] ctrl_r;
  logic [5:0] prot_r;
  logic [31:0] lock_r;
  sfes_state_type state_r;
  sfes_kind_type kind_r, kind_new, nest_kind_r;
  logic [31:0] base_r, nest_base_r, remain_r, nest_remain_r, dur_new;
  logic [15:0] lat_r;
  logic susp_r, wlatch_r, nest_busy_r, refused_r;
  logic is_blk, is_chip, is_prog, len_ok, prot_hit, any_prot, forbid;
  logic req_ok, accept_main, accept_nest, refuse, accept_susp, accept_res;
  logic wren, wrdi, main_done, nest_done, opc_only;
  logic [9:0] bp_cnt;
  logic [8:0] blk;
  logic in_range;
  logic wr_en_r;
  logic [7:0] wr_adr_r;
  logic [31:0] rd_mux;

  // link pins pass two flops before use
  sfes_sync #(.W(6)) u_sync (
    .clk(clk),
    .rst(rst),
    .d(link_in),
    .q(link_q)
  );

  // edge finders on synchronised pins
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_d_r <= 1'b1; // matches the synchroniser reset level, no false edge
      cs_d_r <= 1'b1;
    end else begin
      sck_d_r <= link_q.sck;
      cs_d_r <= link_q.cs_n;
    end
  end
  assign sck_rise = link_q.sck & ~sck_d_r;
  assign cs_rise = link_q.cs_n & ~cs_d_r;

  // header length by opcode and address mode
  always_comb begin
    hdr_bits = ctrl_r[CTRL_ADDR4_BIT] ? HDR4_BITS : HDR3_BITS;
    if (op_r == CMD_SECTOR_ERASE_A32 || op_r == CMD_BLOCK64_ERASE_A32 ||
        op_r == CMD_PAGE_PROG_A32 || op_r == CMD_QUAD_PROG_A32) begin
      hdr_bits = HDR4_BITS;
    end
  end
  assign quad_data = (op_r == CMD_QUAD_PROG || op_r == CMD_QUAD_PROG_A32) &&
                     cnt_r >= hdr_bits;
  assign step4 = ctrl_r[CTRL_QUAD_BIT] | quad_data;

  // shift opcode and address in on rising clock edges
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 12'h000;
      op_r <= 8'h00;
      adr_r <= 32'h0000_0000;
    end else if (link_q.cs_n) begin
      cnt_r <= 12'h000;
    end else if (sck_rise && cnt_r < CNT_SAT) begin
      cnt_r <= cnt_r + (step4 ? 12'h004 : 12'h001);
      if (cnt_r < OPCODE_BITS) begin
        op_r <= step4 ? {op_r[3:0], link_q.io} : {op_r[6:0], link_q.io[0]};
      end else if (cnt_r < hdr_bits) begin
        adr_r <= step4 ? {adr_r[27:0], link_q.io} : {adr_r[30:0], link_q.io[0]};
      end
    end
  end

  // command class and length check
  assign is_blk = op_r == CMD_SECTOR_ERASE || op_r == CMD_SECTOR_ERASE_A32 ||
                  op_r == CMD_BLOCK32_ERASE || op_r == CMD_BLOCK64_ERASE ||
                  op_r == CMD_BLOCK64_ERASE_A32;
  assign is_chip = op_r == CMD_CHIP_ERASE_A || op_r == CMD_CHIP_ERASE_B;
  assign is_prog = op_r == CMD_PAGE_PROG || op_r == CMD_PAGE_PROG_A32 ||
                   op_r == CMD_QUAD_PROG || op_r == CMD_QUAD_PROG_A32;
  assign opc_only = cnt_r == OPCODE_BITS;
  always_comb begin
    len_ok = 1'b0;
    if (is_chip) begin
      len_ok = opc_only;
    end else if (is_blk) begin
      len_ok = cnt_r == hdr_bits;
    end else if (is_prog) begin
      len_ok = cnt_r >= hdr_bits + DATA_BYTE_BITS && cnt_r[2:0] == 3'h0;
    end
  end
  assign tgt = (hdr_bits == HDR4_BITS) ? adr_r : {8'h00, adr_r[23:0]};
  assign blk = tgt[24:16];

  // kind, aligned base and duration of a new operation
  always_comb begin
    kind_new = K_PROGRAM;
    base_new = {7'h00, tgt[24:0]};
    dur_new = PROGRAM_CYC;
    if (is_chip) begin
      kind_new = K_CHIP;
      base_new = 32'h0000_0000;
      dur_new = CHIP_CYC;
    end else if (op_r == CMD_BLOCK32_ERASE) begin
      kind_new = K_BLOCK32;
      base_new = {7'h00, tgt[24:15], 15'h0000};
      dur_new = BLOCK32_CYC;
    end else if (op_r == CMD_BLOCK64_ERASE || op_r == CMD_BLOCK64_ERASE_A32) begin
      kind_new = K_BLOCK64;
      base_new = {7'h00, tgt[24:16], 16'h0000};
      dur_new = BLOCK64_CYC;
    end else if (is_blk) begin
      kind_new = K_SECTOR;
      base_new = {7'h00, tgt[24:12], 12'h000};
      dur_new = SECTOR_CYC;
    end
  end

  // protected range from level, top/bottom and complement
  always_comb begin
    if (prot_r[3:0] == 4'h0) begin
      bp_cnt = 10'h000;
    end else if (prot_r[3:0] >= 4'ha) begin
      bp_cnt = 10'(BLOCK64_TOTAL);
    end else begin
      bp_cnt = 10'h001 << (prot_r[3:0] - 4'h1);
    end
    in_range = prot_r[PROT_TOP_BOTTOM_BIT] ? ({1'b0, blk} < bp_cnt) :
               ({1'b0, blk} >= 10'(BLOCK64_TOTAL) - bp_cnt);
    prot_hit = (in_range ^ prot_r[PROT_COMPLEMENT_BIT]) | lock_r[blk[8:4]];
    any_prot = (prot_r[PROT_COMPLEMENT_BIT] ? bp_cnt != 10'(BLOCK64_TOTAL) :
                bp_cnt != 10'h000) | (|lock_r);
  end

  // acceptance of erase and program
  assign forbid = susp_r & ((kind_r != K_PROGRAM & (is_blk | is_chip)) |
                            (kind_r == K_PROGRAM & is_prog));
  assign req_ok = cs_rise & (is_blk | is_chip | is_prog) & len_ok & wlatch_r &
                  ~(is_chip ? any_prot : prot_hit) & ~forbid;
  assign accept_main = req_ok & state_r == ST_IDLE & ~nest_busy_r;
  assign accept_nest = req_ok & state_r == ST_SUSPENDED & ~nest_busy_r;
  assign refuse = cs_rise & (is_blk | is_chip | is_prog) & ~accept_main & ~accept_nest;
  assign accept_susp = cs_rise & op_r == CMD_SUSPEND & opc_only & ~susp_r &
                       busy_flag & state_r == ST_RUN & kind_r != K_CHIP;
  assign accept_res = cs_rise & op_r == CMD_RESUME & opc_only & susp_r & ~busy_flag &
                      state_r == ST_SUSPENDED;
  assign wren = cs_rise & op_r == CMD_WRITE_ENABLE & opc_only & ~busy_flag;
  assign wrdi = cs_rise & op_r == CMD_WRITE_DISABLE & opc_only & ~busy_flag;
  assign main_done = state_r == ST_RUN & remain_r == 32'h0 & ~accept_susp;
  assign nest_done = nest_busy_r & nest_remain_r == 32'h0;
  assign busy_flag = state_r == ST_RUN || state_r == ST_SUSPENDING || nest_busy_r;

  // main self-timed sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      kind_r <= K_NONE;
      base_r <= 32'h0000_0000;
      remain_r <= 32'h0000_0000;
      lat_r <= 16'h0000;
    end else begin
      unique case (state_r)
        ST_IDLE: if (accept_main) begin
          state_r <= ST_RUN;
          kind_r <= kind_new;
          base_r <= base_new;
          remain_r <= dur_new;
        end
        ST_RUN: if (accept_susp) begin
          state_r <= ST_SUSPENDING;
          lat_r <= 16'(SUSPEND_LAT_CYC - 1);
        end else if (remain_r == 32'h0) begin
          state_r <= ST_IDLE;
          kind_r <= K_NONE;
        end else begin
          remain_r <= remain_r - 32'h1;
        end
        ST_SUSPENDING: if (lat_r == 16'h0) begin
          state_r <= ST_SUSPENDED;
        end else begin
          lat_r <= lat_r - 16'h1;
        end
        ST_SUSPENDED: if (accept_res) begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  // operation run inside a suspension
  always_ff @(posedge clk) begin
    if (rst) begin
      nest_busy_r <= 1'b0;
      nest_kind_r <= K_NONE;
      nest_base_r <= 32'h0000_0000;
      nest_remain_r <= 32'h0000_0000;
    end else if (accept_nest) begin
      nest_busy_r <= 1'b1;
      nest_kind_r <= kind_new;
      nest_base_r <= base_new;
      nest_remain_r <= dur_new;
    end else if (nest_done) begin
      nest_busy_r <= 1'b0;
    end else if (nest_busy_r) begin
      nest_remain_r <= nest_remain_r - 32'h1;
    end
  end

  // suspend flag, cleared by reset
  always_ff @(posedge clk) begin
    if (rst) begin
      susp_r <= 1'b0;
    end else if (accept_susp) begin
      susp_r <= 1'b1;
    end else if (accept_res) begin
      susp_r <= 1'b0;
    end
  end

  // write latch
  always_ff @(posedge clk) begin
    if (rst) begin
      wlatch_r <= 1'b0;
    end else if (wren) begin
      wlatch_r <= 1'b1;
    end else if (wrdi || main_done || nest_done) begin
      wlatch_r <= 1'b0;
    end
  end

  // completion report
  always_ff @(posedge clk) begin
    if (rst) begin
      erase_report <= '0;
    end else begin
      erase_report.valid <= main_done | nest_done;
      if (main_done) begin
        erase_report.kind <= kind_r;
        erase_report.base <= base_r;
      end else if (nest_done) begin
        erase_report.kind <= nest_kind_r;
        erase_report.base <= nest_base_r;
      end
    end
  end

  // ahb address phase capture
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_en_r <= 1'b0;
      wr_adr_r <= 8'h00;
    end else if (hready) begin
      wr_en_r <= hsel & htrans[1] & hwrite;
      wr_adr_r <= haddr[7:0];
    end
  end

  // software registers; protection frozen while busy or suspended
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
      prot_r <= PROTECT_RST;
      lock_r <= LOCK_RST;
    end else if (wr_en_r) begin
      if (wr_adr_r == REG_CTRL) begin
        ctrl_r <= hwdata[1:0];
      end
      if (!busy_flag && !susp_r) begin
        if (wr_adr_r == REG_PROTECT) begin
          prot_r <= hwdata[5:0];
        end
        if (wr_adr_r == REG_LOCK) begin
          lock_r <= hwdata;
        end
      end
    end
  end

  // refused flag, set wins over write-one clear
  always_ff @(posedge clk) begin
    if (rst) begin
      refused_r <= 1'b0;
    end else if (refuse) begin
      refused_r <= 1'b1;
    end else if (wr_en_r && wr_adr_r == REG_STATUS && hwdata[STAT_REFUSED_BIT]) begin
      refused_r <= 1'b0;
    end
  end

  // read data registered at the address phase
  always_comb begin
    unique case (haddr[7:0])
      REG_CTRL: rd_mux = {30'h0, ctrl_r};
      REG_PROTECT: rd_mux = {26'h0, prot_r};
      REG_LOCK: rd_mux = lock_r;
      REG_STATUS: rd_mux = {28'h0, refused_r, susp_r, wlatch_r, busy_flag};
      REG_LAST_BASE: rd_mux = erase_report.base;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= rd_mux;
    end
  end
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0; // always okay
  assign write_latch_flag = wlatch_r;
  assign suspend_flag = susp_r;

  // checks
  busy_rises_a: assert property (@(posedge clk) disable iff (rst)
    accept_main |=> busy_flag ##0 state_r == ST_RUN) else $error("erase not started");
  latch_clear_a: assert property (@(posedge clk) disable iff (rst)
    main_done |=> !write_latch_flag && !busy_flag) else $error("latch kept after erase");
  no_latch_a: assert property (@(posedge clk) disable iff (rst)
    cs_rise && is_blk && !wlatch_r && !busy_flag && !susp_r |=> !busy_flag)
    else $error("erase ran without latch");
  protect_blk_a: assert property (@(posedge clk) disable iff (rst)
    cs_rise && is_blk && prot_hit && state_r == ST_IDLE |=> state_r == ST_IDLE)
    else $error("protected block erased");
  protect_chip_a: assert property (@(posedge clk) disable iff (rst)
    cs_rise && is_chip && any_prot && state_r == ST_IDLE |=> state_r == ST_IDLE)
    else $error("protected array erased");
  susp_ignore_a: assert property (@(posedge clk) disable iff (rst)
    cs_rise && op_r == CMD_SUSPEND && (susp_r || !busy_flag) |=> $stable(suspend_flag))
    else $error("suspend not ignored");
  chip_nosusp_a: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_RUN && kind_r == K_CHIP && !susp_r |=> !suspend_flag)
    else $error("whole-array erase suspended");
  susp_latency_a: assert property (@(posedge clk) disable iff (rst)
    accept_susp |=> suspend_flag ##[1:SUS_BOUND] !busy_flag)
    else $error("busy not dropped within latency");
  resume_busy_a: assert property (@(posedge clk) disable iff (rst)
    accept_res |=> !suspend_flag ##0 (##[0:RES_BOUND] busy_flag))
    else $error("busy late after resume");
  addr_len_a: assert property (@(posedge clk) disable iff (rst)
    cs_rise && op_r == CMD_SECTOR_ERASE_A32 && cnt_r != HDR4_BITS |-> !accept_main)
    else $error("short address accepted");
  sector_base_a: assert property (@(posedge clk) disable iff (rst)
    main_done && kind_r == K_SECTOR |=> erase_report.valid && erase_report.base[11:0] == 12'h0)
    else $error("sector report wrong");
  erase_cov: cover property (@(posedge clk) disable iff (rst) main_done && kind_r == K_SECTOR);
  susp_cov: cover property (@(posedge clk) disable iff (rst) accept_susp);
  resume_cov: cover property (@(posedge clk) disable iff (rst) accept_res);
  nest_cov: cover property (@(posedge clk) disable iff (rst) accept_nest);
endmodule : sfes_core

// file: verilog/sfes_sync.sv
// two-flop synchroniser for a group of asynchronous levels
// assumes nothing reads the first stage
`timescale 1ns/1ps
module sfes_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '1;
      q <= '1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : sfes_sync
